// >>> adc_seq_ctrl.sv
// Sample sequencer controller: registers, triggers, arbitration, averaging
`timescale 1ns/1ps
// Operation
// RULE1 - Four sequencers, depths eight, four, four, one
// RULE2 - Each step picks any channel or temperature
// RULE3 - Each sequencer starts on its own trigger
// RULE4 - Highest priority pending sequencer served first
// RULE5 - Software keeps frequent triggers at low priority
// RULE6 - Hardware averaging over 2 to 64 conversions
// RULE7 - One averaging factor shared by all sequencers
// RULE8 - Software oversampling groups consecutive steps per value
// RULE9 - Per-sequencer enable; disabled ones ignore triggers
// RULE10 - Sticky FIFO overflow and underflow flags, clearable
// RULE11 - Software trigger starts sequencers set to it
// RULE12 - Per-sequencer interrupt, mask, raw, masked, clear
// RULE13 - Busy while any requested sample is outstanding
// RULE14 - Software sets triggers to never before sleep
// RULE15 - Rate setting keeps every 1,2,4,8 sample
// RULE16 - Converter clock divider from 1 to 64
// RULE17 - Results leave FIFO in step order
// RULE18 - Interrupt raised when flagged step completes
// RULE19 - Triggers during disable are dropped, not held
module adc_seq_ctrl
    import adc_seq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NSEQ-1:0] ext_trig_i,
    output logic conv_start_o,
    output logic [CHAN_W-1:0] conv_chan_o,
    input wire logic core_done_i,
    input wire logic [RES_W-1:0] core_data_i,
    output logic irq_o
);
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_CONV} seq_state_t;

    // Configuration and status registers
    logic [NSEQ-1:0] en_q; // Sequencer enables
    logic [2:0] hwavg_q; // Shared averaging shift
    logic [2*NSEQ-1:0] trig_q; // Trigger sources
    logic [2*NSEQ-1:0] prio_q; // Priorities, 0 is highest
    logic [2*NSEQ-1:0] swovs_q; // Software oversampling shifts
    logic [5:0] clkdiv_q; // Divider minus one
    logic [1:0] rate_q; // Sample rate shift
    logic [NSEQ-1:0] ris_q; // Raw interrupt status
    logic [NSEQ-1:0] im_q; // Interrupt mask
    logic [NSEQ-1:0] ovf_q; // Sticky overflow flags
    logic [NSEQ-1:0] unf_q; // Sticky underflow flags
    step_cfg_t steps_q [NSTEP]; // Step table
    // Bus side
    logic ack_q;
    logic [31:0] dat_q;
    logic wr;
    logic rd;
    logic [31:0] bm;
    logic [31:0] rdata_v;
    logic [31:0] wd; // Merged write value
    logic [31:0] w1; // Lane-masked write value
    logic step_hit;
    logic [4:0] step_idx;
    logic fifo_hit;
    logic [NSEQ-1:0] pop_v;
    // Trigger path
    logic [NSEQ-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [NSEQ-1:0] rise_v;
    logic [NSEQ-1:0] swt_v;
    logic [NSEQ-1:0] trig_ev;
    logic [NSEQ-1:0] pend_q;
    // Arbitration
    logic [1:0] win_v;
    logic [1:0] best_v;
    logic found_v;
    logic [NSEQ-1:0] grant_v;
    // Conversion engine
    seq_state_t st_q;
    logic [1:0] cur_q;
    logic [4:0] step_q;
    logic [5:0] hwcnt_q;
    logic [2:0] swcnt_q;
    logic [ACC_W-1:0] acc_hw_q;
    logic [ACC_W-1:0] acc_sw_q;
    logic [9:0] tcnt_q;
    logic [9:0] period_v;
    logic tick_q;
    logic conv_q;
    logic [CHAN_W-1:0] chan_q;
    res_push_t push_q;
    logic [NSEQ-1:0] int_ev_q;
    logic busy_q;
    logic irq_q;
    step_cfg_t cfg_v;
    logic [2:0] hwsel;
    logic [1:0] swsel;
    logic [5:0] hwmax;
    logic [2:0] swmax;
    logic [ACC_W-1:0] sum_hw;
    logic [ACC_W-1:0] hw_res;
    logic [ACC_W-1:0] sum_sw;
    logic last_v;
    // FIFO side
    logic [RES_W-1:0] head_v [NSEQ];
    logic [NSEQ-1:0] ovf_p;
    logic [NSEQ-1:0] unf_p;

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign conv_start_o = conv_q;
    assign conv_chan_o = chan_q;
    assign irq_o = irq_q;

    // Bus decode; a request is served once, at the edge that raises ack
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
    assign bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wd = (rdata_v & ~bm) | (wb_dat_i & bm);
    assign w1 = wb_dat_i & bm;
    assign step_hit = (wb_adr_i >= OFS_STEP) && (wb_adr_i < OFS_STEP + 8'(4 * NSTEP));
    assign step_idx = 5'((wb_adr_i - OFS_STEP) >> 2);
    assign fifo_hit = (wb_adr_i >= OFS_FIFO) && (wb_adr_i < OFS_FIFO + 8'(4 * NSEQ));
    assign swt_v = (wr && wb_adr_i == OFS_SWTRIG) ? w1[NSEQ-1:0] : '0;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_v = '0;
        pop_v = '0;
        if (wb_adr_i == OFS_CTRL) begin
            rdata_v[EN_LSB +: NSEQ] = en_q;
            rdata_v[HW_LSB +: 3] = hwavg_q;
        end else if (wb_adr_i == OFS_TRIG) begin
            rdata_v[2*NSEQ-1:0] = trig_q;
        end else if (wb_adr_i == OFS_PRIO) begin
            rdata_v[2*NSEQ-1:0] = prio_q;
        end else if (wb_adr_i == OFS_SWOVS) begin
            rdata_v[2*NSEQ-1:0] = swovs_q;
        end else if (wb_adr_i == OFS_CLK) begin
            rdata_v[DIV_LSB +: 6] = clkdiv_q;
            rdata_v[RATE_LSB +: 2] = rate_q;
        end else if (wb_adr_i == OFS_RIS) begin
            rdata_v[NSEQ-1:0] = ris_q; // RULE12
        end else if (wb_adr_i == OFS_IM) begin
            rdata_v[NSEQ-1:0] = im_q;
        end else if (wb_adr_i == OFS_MIS) begin
            rdata_v[NSEQ-1:0] = ris_q & im_q; // RULE12
        end else if (wb_adr_i == OFS_FLAGS) begin
            rdata_v[OVF_LSB +: NSEQ] = ovf_q; // RULE10
            rdata_v[UNF_LSB +: NSEQ] = unf_q; // RULE10
        end else if (wb_adr_i == OFS_STAT) begin
            rdata_v[BUSY_BIT] = busy_q; // RULE13
        end else if (fifo_hit && wb_adr_i[1:0] == 2'h0) begin
            rdata_v[RES_W-1:0] = head_v[wb_adr_i[3:2]];
            pop_v[wb_adr_i[3:2]] = rd; // RULE17
        end else if (step_hit && wb_adr_i[1:0] == 2'h0) begin
            rdata_v[STEP_W-1:0] = steps_q[step_idx];
        end
    end

    // Wishbone answer: ack one cycle after the request, read data with it
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            dat_q <= rd ? rdata_v : '0;
        end
    end

    // Configuration writes
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            en_q <= '0;
            hwavg_q <= '0;
            trig_q <= '0;
            prio_q <= PRIO_RST;
            swovs_q <= '0;
            clkdiv_q <= DIV_RST;
            rate_q <= RATE_RST;
            im_q <= '0;
        end else if (wr) begin
            if (wb_adr_i == OFS_CTRL) begin
                en_q <= wd[EN_LSB +: NSEQ]; // RULE9
                hwavg_q <= wd[HW_LSB +: 3]; // RULE7
            end else if (wb_adr_i == OFS_TRIG) begin
                trig_q <= wd[2*NSEQ-1:0]; // RULE3
            end else if (wb_adr_i == OFS_PRIO) begin
                prio_q <= wd[2*NSEQ-1:0];
            end else if (wb_adr_i == OFS_SWOVS) begin
                swovs_q <= wd[2*NSEQ-1:0];
            end else if (wb_adr_i == OFS_CLK) begin
                clkdiv_q <= wd[DIV_LSB +: 6]; // RULE16
                rate_q <= wd[RATE_LSB +: 2]; // RULE15
            end else if (wb_adr_i == OFS_IM) begin
                im_q <= wd[NSEQ-1:0]; // RULE12
            end
        end
    end

    // Step table; any channel in any step, repeats allowed
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NSTEP; i++) steps_q[i] <= '0;
        end else if (wr && step_hit && wb_adr_i[1:0] == 2'h0) begin
            steps_q[step_idx] <= wd[STEP_W-1:0]; // RULE2
        end
    end

    // Pin triggers: three stages, a level counts once stages two and three agree
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= ext_trig_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        end
    end
    assign rise_v = s2_q & s3_q & ~lvl_q;

    // Per-sequencer trigger event from its selected source
    for (genvar g = 0; g < NSEQ; g++) begin : g_trig
        always_comb begin
            case (trig_src_t'(trig_q[2*g +: 2]))
                TRG_SOFT: trig_ev[g] = swt_v[g]; // RULE11
                TRG_EXT: trig_ev[g] = rise_v[g]; // RULE3
                TRG_ALWAYS: trig_ev[g] = 1'b1;
                default: trig_ev[g] = 1'b0;
            endcase
        end
    end

    // Pending requests; a new trigger beats the grant clear, disable drops all
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pend_q <= '0;
        end else begin
            pend_q <= ((pend_q & ~grant_v) | trig_ev) & en_q; // RULE9 RULE19
        end
    end

    // Priority pick; equal priorities go to the lower sequencer number
    always_comb begin
        win_v = '0;
        best_v = '1;
        found_v = 1'b0;
        grant_v = '0;
        for (int i = 0; i < NSEQ; i++) begin
            if (pend_q[i] && (!found_v || prio_q[2*i +: 2] < best_v)) begin
                win_v = 2'(i); // RULE4
                best_v = prio_q[2*i +: 2];
                found_v = 1'b1;
            end
        end
        if (st_q == S_IDLE && found_v) grant_v[win_v] = 1'b1;
    end

    // Conversion pacing: divider times rate skip
    assign period_v = 10'(({4'h0, clkdiv_q} + 10'h001) << rate_q);
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tcnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tcnt_q >= period_v - 10'h001) begin
            tcnt_q <= '0; // RULE16 RULE15
            tick_q <= 1'b1;
        end else begin
            tcnt_q <= tcnt_q + 10'h001;
            tick_q <= 1'b0;
        end
    end

    // Averaging arithmetic for the running step
    assign cfg_v = steps_q[step_q];
    assign hwsel = (hwavg_q > HW_MAX_SHIFT) ? HW_MAX_SHIFT : hwavg_q; // RULE7
    assign swsel = swovs_q[2*cur_q +: 2];
    assign hwmax = 6'((7'h01 << hwsel) - 7'h01); // RULE6
    assign swmax = 3'((4'h1 << swsel) - 4'h1); // RULE8
    assign sum_hw = acc_hw_q + ACC_W'(core_data_i);
    assign hw_res = sum_hw >> hwsel;
    assign sum_sw = acc_sw_q + hw_res;
    assign last_v = cfg_v.last || step_q == 5'(SEQ_BASE[cur_q] + SEQ_DEPTH[cur_q] - 1); // RULE1

    // Sequence engine: wait for pacing, convert, average, advance the step
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_q <= S_IDLE;
            cur_q <= '0;
            step_q <= '0;
            hwcnt_q <= '0;
            swcnt_q <= '0;
            acc_hw_q <= '0;
            acc_sw_q <= '0;
            conv_q <= 1'b0;
            chan_q <= '0;
            push_q <= '0;
            int_ev_q <= '0;
        end else begin
            conv_q <= 1'b0;
            push_q.push <= '0;
            int_ev_q <= '0;
            case (st_q)
                S_IDLE: begin
                    if (found_v) begin
                        cur_q <= win_v; // RULE4
                        step_q <= 5'(SEQ_BASE[win_v]);
                        hwcnt_q <= '0;
                        swcnt_q <= '0;
                        acc_hw_q <= '0;
                        acc_sw_q <= '0;
                        st_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (tick_q) begin
                        conv_q <= 1'b1; // RULE16
                        chan_q <= cfg_v.chan; // RULE2
                        st_q <= S_CONV;
                    end
                end
                S_CONV: begin
                    if (core_done_i) begin
                        if (hwcnt_q != hwmax) begin
                            acc_hw_q <= sum_hw; // RULE6
                            hwcnt_q <= hwcnt_q + 6'h01;
                            st_q <= S_WAIT;
                        end else begin
                            acc_hw_q <= '0;
                            hwcnt_q <= '0;
                            if (swcnt_q == swmax) begin
                                push_q.push[cur_q] <= 1'b1; // RULE17
                                push_q.data <= RES_W'(sum_sw >> swsel); // RULE8
                                acc_sw_q <= '0;
                                swcnt_q <= '0;
                            end else begin
                                acc_sw_q <= sum_sw; // RULE8
                                swcnt_q <= swcnt_q + 3'h1;
                            end
                            if (cfg_v.ie) int_ev_q[cur_q] <= 1'b1; // RULE18
                            if (last_v) begin
                                st_q <= S_IDLE;
                            end else begin
                                step_q <= step_q + 5'h01;
                                st_q <= S_WAIT;
                            end
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Result FIFOs, one per sequencer at its own depth
    for (genvar g = 0; g < NSEQ; g++) begin : g_fifo
        res_fifo #(
            .DEPTH(SEQ_DEPTH[g]),
            .W(RES_W)
        ) u_fifo (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .push_i(push_q.push[g]),
            .data_i(push_q.data),
            .pop_i(pop_v[g]),
            .head_o(head_v[g]),
            .empty_o(),
            .ovf_o(ovf_p[g]),
            .unf_o(unf_p[g])
        );
    end

    // Sticky flags and interrupt status; write one clears, a new event wins
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ris_q <= '0;
            ovf_q <= '0;
            unf_q <= '0;
            irq_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (wr && wb_adr_i == OFS_RIS) begin
                ris_q <= (ris_q & ~w1[NSEQ-1:0]) | int_ev_q; // RULE12
            end else begin
                ris_q <= ris_q | int_ev_q;
            end
            if (wr && wb_adr_i == OFS_FLAGS) begin
                ovf_q <= (ovf_q & ~w1[OVF_LSB +: NSEQ]) | ovf_p; // RULE10
                unf_q <= (unf_q & ~w1[UNF_LSB +: NSEQ]) | unf_p; // RULE10
            end else begin
                ovf_q <= ovf_q | ovf_p;
                unf_q <= unf_q | unf_p;
            end
            irq_q <= |(ris_q & im_q); // RULE12
            busy_q <= (st_q != S_IDLE) || (|pend_q); // RULE13
        end
    end

    a_dis_ignores: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE19
        ##1 !(|(pend_q & ~$past(en_q))))
        else $error("pending request on a disabled sequencer");
    a_prio_first: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE4
        (st_q == S_IDLE && pend_q == 4'h9 && prio_q[7:6] < prio_q[1:0]) |=> cur_q == 2'h3)
        else $error("top priority sequencer not served first");
    a_start_tick: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE16
        conv_q |-> $past(tick_q) && $past(st_q) == S_WAIT)
        else $error("conversion started off the pacing tick");
    a_hw_group: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE6
        (|push_q.push) |-> $past(hwcnt_q) == $past(hwmax))
        else $error("result pushed before averaging completed");
    a_sw_group: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE8
        (|push_q.push) |-> $past(swcnt_q) == $past(swmax))
        else $error("result pushed before oversampling group completed");
    a_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE12
        ##1 irq_q == |($past(ris_q) & $past(im_q)))
        else $error("interrupt output does not follow masked status");
    a_swtrig_pend: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11
        (swt_v[0] && en_q[0] && trig_q[1:0] == 2'(TRG_SOFT)) |=> pend_q[0])
        else $error("software trigger lost");
    a_busy_conv: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE13
        (st_q == S_CONV) |=> busy_q)
        else $error("busy low during a conversion");
    a_int_step: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE18
        (|int_ev_q) |-> $past(cfg_v.ie) && $past(core_done_i))
        else $error("interrupt event without flagged step completion");
endmodule

// >>> adc_seq_pkg.sv
// Shared constants and types of the sample sequencer controller
package adc_seq_pkg;
    // Sequencer geometry
    localparam int NSEQ = 4;
    localparam int NSTEP = 17;
    localparam int SEQ_DEPTH [NSEQ] = '{8, 4, 4, 1};
    localparam int SEQ_BASE [NSEQ] = '{0, 8, 12, 16};
    // Data widths
    localparam int RES_W = 12;
    localparam int ACC_W = 21;
    localparam int CHAN_W = 5;
    localparam int ADR_W = 8;
    // Highest hardware averaging shift (64 conversions)
    localparam logic [2:0] HW_MAX_SHIFT = 3'h6;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TRIG = 8'h04;
    localparam logic [7:0] OFS_PRIO = 8'h08;
    localparam logic [7:0] OFS_SWOVS = 8'h0C;
    localparam logic [7:0] OFS_SWTRIG = 8'h10;
    localparam logic [7:0] OFS_CLK = 8'h14;
    localparam logic [7:0] OFS_RIS = 8'h18;
    localparam logic [7:0] OFS_IM = 8'h1C;
    localparam logic [7:0] OFS_MIS = 8'h20;
    localparam logic [7:0] OFS_FLAGS = 8'h24;
    localparam logic [7:0] OFS_STAT = 8'h28;
    localparam logic [7:0] OFS_FIFO = 8'h40;
    localparam logic [7:0] OFS_STEP = 8'h80;
    // Field positions
    localparam int EN_LSB = 0;
    localparam int HW_LSB = 4;
    localparam int DIV_LSB = 0;
    localparam int RATE_LSB = 8;
    localparam int OVF_LSB = 0;
    localparam int UNF_LSB = 4;
    localparam int BUSY_BIT = 0;
    // Reset values
    localparam logic [7:0] PRIO_RST = 8'hE4;
    localparam logic [5:0] DIV_RST = 6'h00;
    localparam logic [1:0] RATE_RST = 2'h0;
    // Trigger source of one sequencer
    typedef enum logic [1:0] {
        TRG_NEVER,
        TRG_SOFT,
        TRG_EXT,
        TRG_ALWAYS
    } trig_src_t;
    // One step of a sequence
    typedef struct packed {
        logic ie;
        logic last;
        logic [CHAN_W-1:0] chan;
    } step_cfg_t;
    localparam int STEP_W = $bits(step_cfg_t);
    // One result on its way to a FIFO
    typedef struct packed {
        logic [NSEQ-1:0] push;
        logic [RES_W-1:0] data;
    } res_push_t;
endpackage

// >>> res_fifo.sv
// Result FIFO of one sample sequencer with overflow and underflow pulses
`timescale 1ns/1ps
module res_fifo
    import adc_seq_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int W = RES_W
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic [W-1:0] data_i,
    input wire logic pop_i,
    output logic [W-1:0] head_o,
    output logic empty_o,
    output logic ovf_o,
    output logic unf_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_q [DEPTH]; // Storage
    logic [AW-1:0] wp_q; // Write index
    logic [AW-1:0] rp_q; // Read index
    logic [CW-1:0] cnt_q; // Fill level
    logic full;
    logic empty;
    logic do_push;
    logic do_pop;

    // Next index with wrap at depth
    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign full = (cnt_q == CW'(DEPTH));
    assign empty = (cnt_q == '0);
    assign do_push = push_i && !full;
    assign do_pop = pop_i && !empty;
    assign head_o = empty ? '0 : mem_q[rp_q];
    assign empty_o = empty;

    // Pointers and fill level, results leave in arrival order
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) wp_q <= inc(wp_q); // RULE17
            if (do_pop) rp_q <= inc(rp_q); // RULE17
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Storage write
    always_ff @(posedge mclk_i) begin
        if (do_push) mem_q[wp_q] <= data_i;
    end

    // Error pulses: write while full, read while empty
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ovf_o <= 1'b0;
            unf_o <= 1'b0;
        end else begin
            ovf_o <= push_i && full; // RULE10
            unf_o <= pop_i && empty; // RULE10
        end
    end

    a_ovf_on_full: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE10
        (push_i && full) |=> ovf_o && $stable(wp_q))
        else $error("push into full fifo not flagged");
    a_unf_on_empty: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE10
        (pop_i && empty) |=> unf_o && $stable(rp_q))
        else $error("pop from empty fifo not flagged");
endmodule

// >>> adc_core_model.sv
// Behavioural analog core that answers each conversion start
`timescale 1ns/1ps
module adc_core_model
    import adc_seq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [CHAN_W-1:0] chan_i,
    input wire logic slow_i,
    output logic done_o,
    output logic [RES_W-1:0] data_o
);
    logic [2:0] cnt_q; // Cycles left in the conversion
    logic [RES_W-1:0] val_q; // Result is channel times 16 plus 3
    // Result bus shows the inverse of the result outside the done cycle
    always_ff @(posedge mclk_i) begin
        done_o <= 1'b0;
        data_o <= ~val_q;
        if (rst_i) begin
            cnt_q <= 3'h0;
            val_q <= 12'h000;
        end else if (start_i) begin
            cnt_q <= slow_i ? 3'h6 : 3'h1;
            val_q <= {3'h0, chan_i, 4'h3};
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
            done_o <= (cnt_q == 3'h1);
            data_o <= (cnt_q == 3'h1) ? val_q : ~val_q;
        end
    end
endmodule

// >>> tb_top.sv
// Self-checking bench of the sample sequencer controller
`timescale 1ns/1ps
module tb_top
    import adc_seq_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat_o, rdat;
    logic ack, start, done, irq;
    logic slow = 1'b0; // Core answers slowly when set
    logic [3:0] xtrig = 4'h0; // Pin triggers, one per sequencer
    logic [CHAN_W-1:0] chan;
    logic [RES_W-1:0] cdat;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [CHAN_W-1:0] seen_q[$]; // Channels of conversions started
    always #5 mclk_i = ~mclk_i;
    adc_seq_ctrl i_adc_seq_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat_o), .wb_ack_o(ack), .ext_trig_i(xtrig), .conv_start_o(start),
        .conv_chan_o(chan), .core_done_i(done), .core_data_i(cdat), .irq_o(irq));
    adc_core_model i_adc_core_model (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start),
        .chan_i(chan), .slow_i(slow), .done_o(done), .data_o(cdat));
    // Log conversions and cut a hang short
    always @(posedge mclk_i) begin
        if (start === 1'b1) begin
            seen_q.push_back(chan);
        end
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test;
        end
    end
    task automatic stop_test;
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // One classic Wishbone cycle, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk_i);
        end while (ack !== 1'b1);
        rdat = rdat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(s, rdat, e);
    endtask
    // Poll busy until the engine is idle
    task automatic idle;
        rdat = 32'h1;
        while (rdat[0] !== 1'b0) begin
            bus(1'b0, OFS_STAT, 32'h0);
        end
    endtask
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd("prio", OFS_PRIO, 32'h000000E4);
        rd("unmapped", 8'h30, 32'h0);
        wr(OFS_CLK, 32'h0000023F);
        rd("clk", OFS_CLK, 32'h0000023F);
        wr(OFS_CLK, 32'h0);
        // Sequencer 1: channel 3, temperature sensor, channel 3 with interrupt
        wr(8'hA0, 32'h03);
        wr(8'hA4, 32'h18);
        wr(8'hA8, 32'h63);
        wr(OFS_TRIG, 32'h14);
        wr(OFS_IM, 32'h2);
        wr(OFS_CTRL, 32'h2);
        wr(OFS_SWTRIG, 32'h4);
        wr(OFS_SWTRIG, 32'h2);
        idle;
        chk("starts", 32'(seen_q.size()), 32'h3);
        chk("irq", {31'h0, irq}, 32'h1);
        rd("masked", OFS_MIS, 32'h2);
        rd("fifo a", 8'h44, 32'h033);
        rd("fifo b", 8'h44, 32'h183);
        rd("fifo c", 8'h44, 32'h033);
        rd("fifo empty", 8'h44, 32'h0);
        rd("underflow", OFS_FLAGS, 32'h20);
        wr(OFS_FLAGS, 32'hFF);
        wr(OFS_RIS, 32'h2);
        rd("flags clear", OFS_FLAGS, 32'h0);
        chk("irq clear", {31'h0, irq}, 32'h0);
        // Late enable of sequencer 2 must not run a dropped trigger
        wr(OFS_CTRL, 32'h6);
        idle;
        chk("dropped", 32'(seen_q.size()), 32'h3);
        // Four steps folded into one value by software oversampling
        wr(8'hA0, 32'h00);
        wr(8'hA4, 32'h04);
        wr(8'hA8, 32'h08);
        wr(8'hAC, 32'h0C);
        wr(OFS_SWOVS, 32'h8);
        slow <= 1'b1;
        wr(OFS_SWTRIG, 32'h2);
        idle;
        rd("sw avg", 8'h44, 32'h063);
        rd("sw depth", 8'h44, 32'h0);
        // Shared 4x hardware averaging, priority and overflow
        wr(OFS_FLAGS, 32'hFF);
        wr(8'hC0, 32'h67);
        wr(8'h80, 32'h22);
        wr(OFS_TRIG, 32'h41);
        wr(OFS_PRIO, 32'h27);
        wr(OFS_CTRL, 32'h29);
        seen_q.delete();
        wr(OFS_SWTRIG, 32'h8);
        idle;
        wr(OFS_SWTRIG, 32'h9);
        idle;
        chk("hw count", 32'(seen_q.size()), 32'hC);
        chk("first", {27'h0, seen_q[4]}, 32'h7);
        chk("second", {27'h0, seen_q[8]}, 32'h2);
        rd("overflow", OFS_FLAGS, 32'h08);
        rd("fifo 3", 8'h4C, 32'h073);
        rd("fifo 0", 8'h40, 32'h023);
        rd("raw", OFS_RIS, 32'h8);
        chk("masked irq", {31'h0, irq}, 32'h0);
        // Pin trigger through the synchroniser runs sequencer 0 once
        seen_q.delete();
        xtrig <= 4'h1;
        wr(OFS_TRIG, 32'h2);
        repeat (4) @(posedge mclk_i);
        idle;
        chk("pin count", 32'(seen_q.size()), 32'h4);
        rd("fifo pin", 8'h40, 32'h023);
        // Always trigger at lowest priority keeps busy high until set to never
        wr(OFS_TRIG, 32'h3);
        rd("busy on", OFS_STAT, 32'h1);
        wr(OFS_TRIG, 32'h0);
        idle;
        rd("busy", OFS_STAT, 32'h0);
        stop_test;
    end
endmodule
